// ==== src/tpw_defines.svh ====
// constants for the three-phase pwm timer: count sources, mode codes, register indices.
// assumes a single 40 MHz clock; software reaches the registers through plain ports.
// Function
// - reset-sync mode ignores output-control and dead-time settings but not the level selects; mode codes 10/11 turn it off
// - reset-sync: ch0 compare a is the period; ch0 c pin toggles every period
// - reset-sync: ch0 b, ch1 a, ch1 b set change points of three outputs
// - reset-sync: compare c and d feed the match interrupt whether their buffer enables are 0 or 1
// - reset-sync, ch0 c buffer enable set: ch0 compare c holds the next period
// - buffer enables set: ch0 d, ch1 c, ch1 d hold next change points
// - complementary: three normal and three counter outputs, triangle carrier, dead time
// - count source: f1, f2, f4, f8, f32, oscillator, or external pin edge
// - counting up, counter 0 matching ch0 compare a turns both counters down
// - counting down, counter 1 wrapping 0000h to ffffh turns both counters up
// - complementary period is 2*(m+2-p) count-source periods
// - dead time is the value p loaded into counter 0
// - normal-phase active width is 2*(m-n-p+1) count-source periods
// - counter-phase active width is 2*(n+1-p) count-source periods
// - n comes from ch0 b, ch1 a, ch1 b for outputs one to three
// - counting starts when both channel start bits are written 1
// - counting stops when both start bits are written 0 with stop select 1
// - interrupt request on every compare match and on counter 1 underflow
// - complementary: ch0 c pin toggles every half pwm period
// - once counting starts in complementary mode the period stays fixed
// - mode code 10 transfers buffers at underflow, 11 at compare a match
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

`define TPW_CW 16
`define TPW_CNT_ZERO 16'h0000
`define TPW_CNT_MAX 16'hffff
`define TPW_PRESC_W 5

`define TPW_SRC_F1 3'h0
`define TPW_SRC_F2 3'h1
`define TPW_SRC_F4 3'h2
`define TPW_SRC_F8 3'h3
`define TPW_SRC_F32 3'h4
`define TPW_SRC_EXT 3'h5
`define TPW_SRC_OCO 3'h6

`define TPW_EDGE_RISE 2'h0
`define TPW_EDGE_FALL 2'h1

`define TPW_CMB_UDF 2'h2
`define TPW_CMB_MATCH 2'h3

`define TPW_IDX_CNT0 4'h0
`define TPW_IDX_CNT1 4'h1
`define TPW_IDX_CMP_BASE 4'h2
`define TPW_IDX_CMP_LAST 4'h9

`define TPW_A0 3'h0
`define TPW_B0 3'h1
`define TPW_C0 3'h2
`define TPW_D0 3'h3
`define TPW_A1 3'h4
`define TPW_B1 3'h5
`define TPW_C1 3'h6
`define TPW_D1 3'h7

`endif

// ==== src/tpw_pkg.sv ====
// types shared by the three-phase pwm timer.
// assumes tpw_defines.svh supplies the numeric constants.
package tpw_pkg;
	typedef enum logic [1:0] {
		TPW_STOPPED = 2'h0,
		TPW_COUNT_UP = 2'h1,
		TPW_COUNT_DOWN = 2'h3
	} tpw_state_e;
endpackage : tpw_pkg

// ==== src/tpw_count_src.sv ====
// count-source selection: prescaled system clock or edges of an outside clock.
// assumes the pin and oscillator inputs are asynchronous to i_clk.
`include "tpw_defines.svh"
module tpw_count_src
	import tpw_pkg::*;
#(
	parameter int PRESC_W = `TPW_PRESC_W
) (
	input wire logic i_clk, // system clock
	input wire logic i_sys_rst, // async reset, active high
	input wire logic [2:0] i_clock_source_select, // source code
	input wire logic [1:0] i_clock_edge_select, // external edge choice
	input wire logic i_external_count_clock_pin, // external count pin
	input wire logic i_onchip_oscillator_clock, // oscillator clock
	output logic o_tick // one-cycle count enable
);
	logic [PRESC_W-1:0] presc_reg;
	logic [2:0] ext_sync_reg;
	logic [2:0] oco_sync_reg;
	logic ext_rise;
	logic ext_fall;

	function automatic logic div_tick(input logic [PRESC_W-1:0] cnt, input int div);
		logic [PRESC_W-1:0] mask;
		mask = PRESC_W'(div - 1);
		return (cnt & mask) == mask;
	endfunction : div_tick

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	// bit 0 only feeds bit 1; edges are taken from bits 1 and 2
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ext_sync_reg <= 3'h0;
			oco_sync_reg <= 3'h0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], i_external_count_clock_pin};
			oco_sync_reg <= {oco_sync_reg[1:0], i_onchip_oscillator_clock};
		end
	end

	assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
	assign ext_fall = !ext_sync_reg[1] && ext_sync_reg[2];

	// the oscillator is sampled, so it only counts right when well below 20 MHz
	always_comb begin
		case (i_clock_source_select)
			`TPW_SRC_F1: o_tick = 1'b1;
			`TPW_SRC_F2: o_tick = div_tick(presc_reg, 2);
			`TPW_SRC_F4: o_tick = div_tick(presc_reg, 4);
			`TPW_SRC_F8: o_tick = div_tick(presc_reg, 8);
			`TPW_SRC_F32: o_tick = div_tick(presc_reg, 32);
			`TPW_SRC_OCO: o_tick = oco_sync_reg[1] && !oco_sync_reg[2];
			`TPW_SRC_EXT: begin
				if (i_clock_edge_select == `TPW_EDGE_RISE) begin
					o_tick = ext_rise;
				end else if (i_clock_edge_select == `TPW_EDGE_FALL) begin
					o_tick = ext_fall;
				end else begin
					o_tick = ext_rise || ext_fall;
				end
			end
			default: o_tick = 1'b0;
		endcase
	end
endmodule : tpw_count_src

// ==== src/tpw_timer.sv ====
// three-phase pwm timer: reset-synchronous and complementary modes.
// assumes software drives the write, read and control ports in the i_clk domain.
`include "tpw_defines.svh"
module tpw_timer
	import tpw_pkg::*;
(
	input wire logic i_clk, // 40 MHz system clock
	input wire logic i_sys_rst, // async reset, active high
	input wire logic i_wr_en, // register write strobe
	input wire logic [3:0] i_wr_index, // register written
	input wire logic [15:0] i_wr_data, // write data
	input wire logic [3:0] i_rd_index, // register read
	output logic [15:0] o_rd_data, // read data, one cycle later
	input wire logic i_start_wr, // start register write strobe
	input wire logic i_ch0_start_bit, // written ch0 start bit
	input wire logic i_ch1_start_bit, // written ch1 start bit
	input wire logic i_ch0_stop_select, // allows stop by writing 0
	input wire logic i_reset_sync_mode, // reset-synchronous mode select
	input wire logic [1:0] i_combination_mode_select, // 10/11 complementary
	input wire logic i_ch0_c_buffer_enable, // ch0 c is buffer, reset-sync mode only
	input wire logic i_ch0_d_buffer_enable, // ch0 d is buffer
	input wire logic i_ch1_c_buffer_enable, // ch1 c is buffer
	input wire logic i_ch1_d_buffer_enable, // ch1 d is buffer
	input wire logic [2:0] i_clock_source_select, // count source code
	input wire logic [1:0] i_clock_edge_select, // external edge choice
	input wire logic i_external_count_clock_pin, // external count pin
	input wire logic i_onchip_oscillator_clock, // oscillator clock
	input wire logic i_normal_level_select, // 1: normal active high
	input wire logic i_counter_level_select, // 1: counter active high
	input wire logic [5:0] i_output_control, // per-pin disable, complementary only
	output logic o_ch0_c_output_pin, // period toggle pin
	output logic o_first_pwm_output_normal_pin, // first output normal phase
	output logic o_first_pwm_output_counter_pin, // first output counter phase
	output logic o_second_pwm_output_normal_pin, // second output normal phase
	output logic o_second_pwm_output_counter_pin, // second output counter phase
	output logic o_third_pwm_output_normal_pin, // third output normal phase
	output logic o_third_pwm_output_counter_pin, // third output counter phase
	output logic o_running, // counting in progress
	output logic o_count_down, // carrier decrementing
	output logic o_match_irq, // compare match pulse
	output logic o_underflow_irq // counter 1 underflow pulse
);
	tpw_state_e state_reg;
	logic [15:0] cnt0_reg;
	logic [15:0] cnt1_reg;
	logic [15:0] cmp_reg [0:7];
	logic [15:0] period_reg;
	logic [2:0] rs_act_reg;
	logic [2:0] nrm_act;
	logic [2:0] ctr_act;
	logic [5:0] pin_reg;
	logic ch0c_reg;
	logic tick;
	logic comp_mode;
	logic rs_mode;
	logic run_tick;
	logic start_req;
	logic stop_req;
	logic rs_wrap;
	logic comp_top;
	logic comp_udf;
	logic xfer;
	logic any_match;
	logic wr_cmp;
	logic [2:0] wr_cmp_idx;
	logic [7:0] bf_en;

	// compare register holding n for output k, and the buffer feeding it
	function automatic logic [2:0] n_sel(input int k);
		case (k)
			0: return `TPW_B0;
			1: return `TPW_A1;
			default: return `TPW_B1;
		endcase
	endfunction : n_sel

	function automatic logic [2:0] buf_sel(input int k);
		case (k)
			0: return `TPW_D0;
			1: return `TPW_C1;
			default: return `TPW_D1;
		endcase
	endfunction : buf_sel

	function automatic logic lvl(input logic act, input logic active_high);
		return active_high ? act : !act;
	endfunction : lvl

	tpw_count_src u_src (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_clock_source_select(i_clock_source_select),
		.i_clock_edge_select(i_clock_edge_select),
		.i_external_count_clock_pin(i_external_count_clock_pin),
		.i_onchip_oscillator_clock(i_onchip_oscillator_clock),
		.o_tick(tick)
	);

	assign comp_mode = i_combination_mode_select[1];
	assign rs_mode = !comp_mode && i_reset_sync_mode;
	assign run_tick = tick && (state_reg != TPW_STOPPED);
	assign start_req = i_start_wr && i_ch0_start_bit && i_ch1_start_bit;
	assign stop_req = i_start_wr && !i_ch0_start_bit && !i_ch1_start_bit
		&& i_ch0_stop_select;
	assign rs_wrap = rs_mode && run_tick && (cnt0_reg == cmp_reg[`TPW_A0]);
	assign comp_top = comp_mode && run_tick && (state_reg == TPW_COUNT_UP)
		&& (cnt0_reg == period_reg);
	assign comp_udf = comp_mode && run_tick && (state_reg == TPW_COUNT_DOWN)
		&& (cnt1_reg == `TPW_CNT_ZERO);
	assign xfer = rs_wrap
		|| (i_combination_mode_select == `TPW_CMB_UDF && comp_udf)
		|| (i_combination_mode_select == `TPW_CMB_MATCH && comp_top);
	assign bf_en = {i_ch1_d_buffer_enable, i_ch1_c_buffer_enable, 2'h0,
		i_ch0_d_buffer_enable, i_ch0_c_buffer_enable && rs_mode, 2'h0};
	assign wr_cmp = i_wr_en && (i_wr_index >= `TPW_IDX_CMP_BASE)
		&& (i_wr_index <= `TPW_IDX_CMP_LAST);
	assign wr_cmp_idx = 3'(i_wr_index - `TPW_IDX_CMP_BASE);
	assign any_match = run_tick && (rs_mode || comp_mode)
		&& (cnt0_reg == cmp_reg[`TPW_A0] || cnt0_reg == cmp_reg[`TPW_B0]
		|| cnt0_reg == cmp_reg[`TPW_C0] || cnt0_reg == cmp_reg[`TPW_D0]
		|| cnt1_reg == cmp_reg[`TPW_A1] || cnt1_reg == cmp_reg[`TPW_B1]
		|| cnt1_reg == cmp_reg[`TPW_C1] || cnt1_reg == cmp_reg[`TPW_D1]);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_reg <= TPW_STOPPED;
		end else if (stop_req) begin
			state_reg <= TPW_STOPPED;
		end else if (start_req && state_reg == TPW_STOPPED && (comp_mode || rs_mode)) begin
			state_reg <= TPW_COUNT_UP;
		end else if (run_tick) begin
			case (state_reg)
				TPW_COUNT_UP: begin
					if (comp_top) begin
						state_reg <= TPW_COUNT_DOWN;
					end
				end
				TPW_COUNT_DOWN: begin
					if (comp_udf) begin
						state_reg <= TPW_COUNT_UP;
					end
				end
				default: state_reg <= TPW_STOPPED;
			endcase
		end
	end

	// the turn to down lands one count after the match, which gives the +2 in the period
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt0_reg <= `TPW_CNT_ZERO;
			cnt1_reg <= `TPW_CNT_ZERO;
		end else begin
			if (run_tick) begin
				if (rs_wrap) begin
					cnt0_reg <= `TPW_CNT_ZERO;
				end else if (rs_mode) begin
					cnt0_reg <= cnt0_reg + 1'b1;
				end else if (state_reg == TPW_COUNT_UP) begin
					cnt0_reg <= cnt0_reg + 1'b1;
					cnt1_reg <= cnt1_reg + 1'b1;
				end else begin
					cnt0_reg <= cnt0_reg - 1'b1;
					cnt1_reg <= cnt1_reg - 1'b1;
				end
			end
			// a software write wins over the count in the same cycle
			if (i_wr_en && i_wr_index == `TPW_IDX_CNT0) begin
				cnt0_reg <= i_wr_data;
			end
			if (i_wr_en && i_wr_index == `TPW_IDX_CNT1) begin
				cnt1_reg <= i_wr_data;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			period_reg <= `TPW_CNT_ZERO;
		end else if (start_req && state_reg == TPW_STOPPED) begin
			period_reg <= cmp_reg[`TPW_A0];
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int i = 0; i < 8; i++) begin
				cmp_reg[i] <= `TPW_CNT_ZERO;
			end
		end else begin
			if (xfer && bf_en[`TPW_C0]) begin
				cmp_reg[`TPW_A0] <= cmp_reg[`TPW_C0];
			end
			for (int k = 0; k < 3; k++) begin
				if (xfer && bf_en[buf_sel(k)]) begin
					cmp_reg[n_sel(k)] <= cmp_reg[buf_sel(k)];
				end
			end
			if (wr_cmp) begin
				cmp_reg[wr_cmp_idx] <= i_wr_data;
			end
		end
	end

	// reset-sync outputs go active at the period start and drop at their change point
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rs_act_reg <= 3'h0;
		end else if (rs_wrap) begin
			rs_act_reg <= 3'h7;
		end else if (rs_mode && run_tick) begin
			for (int k = 0; k < 3; k++) begin
				if (cnt0_reg == cmp_reg[n_sel(k)]) begin
					rs_act_reg[k] <= 1'b0;
				end
			end
		end
	end

	// counter value ffffh is the wrap state and never counts as normal-phase active
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			if (rs_mode) begin
				nrm_act[k] = rs_act_reg[k];
				ctr_act[k] = !rs_act_reg[k];
			end else if (state_reg == TPW_COUNT_UP) begin
				nrm_act[k] = cnt1_reg != `TPW_CNT_MAX && cnt1_reg > cmp_reg[n_sel(k)];
				ctr_act[k] = cnt0_reg < cmp_reg[n_sel(k)];
			end else begin
				nrm_act[k] = cnt1_reg != `TPW_CNT_MAX && cnt1_reg >= cmp_reg[n_sel(k)];
				ctr_act[k] = cnt0_reg <= cmp_reg[n_sel(k)];
			end
		end
	end

	// pins hold their level while stopped; disables only count in complementary mode
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pin_reg <= 6'h00;
		end else if (state_reg != TPW_STOPPED) begin
			for (int k = 0; k < 3; k++) begin
				pin_reg[2*k] <= lvl(nrm_act[k] && !(comp_mode
					&& i_output_control[2*k]), i_normal_level_select);
				pin_reg[2*k+1] <= lvl(ctr_act[k] && !(comp_mode
					&& i_output_control[2*k+1]), i_counter_level_select);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ch0c_reg <= 1'b0;
		end else if (rs_wrap || comp_top || comp_udf) begin
			ch0c_reg <= !ch0c_reg;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_match_irq <= 1'b0;
			o_underflow_irq <= 1'b0;
		end else begin
			o_match_irq <= any_match;
			o_underflow_irq <= comp_udf;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rd_data <= `TPW_CNT_ZERO;
		end else if (i_rd_index == `TPW_IDX_CNT0) begin
			o_rd_data <= cnt0_reg;
		end else if (i_rd_index == `TPW_IDX_CNT1) begin
			o_rd_data <= cnt1_reg;
		end else if (i_rd_index <= `TPW_IDX_CMP_LAST) begin
			o_rd_data <= cmp_reg[3'(i_rd_index - `TPW_IDX_CMP_BASE)];
		end else begin
			o_rd_data <= `TPW_CNT_ZERO;
		end
	end

	assign o_ch0_c_output_pin = ch0c_reg;
	assign {o_third_pwm_output_counter_pin, o_third_pwm_output_normal_pin, o_second_pwm_output_counter_pin, o_second_pwm_output_normal_pin,
		o_first_pwm_output_counter_pin, o_first_pwm_output_normal_pin} = pin_reg;
	assign o_running = state_reg != TPW_STOPPED;
	assign o_count_down = state_reg == TPW_COUNT_DOWN;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_rs_wrap;
		rs_wrap && !(i_wr_en && i_wr_index == `TPW_IDX_CNT0) |=> cnt0_reg == `TPW_CNT_ZERO;
	endproperty
	a_rs_wrap: assert property (p_rs_wrap) else $error("period wrap missed");

	property p_toggle;
		rs_wrap || comp_top || comp_udf |=> o_ch0_c_output_pin != $past(o_ch0_c_output_pin);
	endproperty
	a_toggle: assert property (p_toggle) else $error("ch0 c pin did not toggle");

	property p_turn_down;
		comp_top && !stop_req |=> state_reg == TPW_COUNT_DOWN;
	endproperty
	a_turn_down: assert property (p_turn_down) else $error("no turn to down");

	property p_turn_up;
		comp_udf && !stop_req && !i_wr_en |=> state_reg == TPW_COUNT_UP
			&& cnt1_reg == `TPW_CNT_MAX;
	endproperty
	a_turn_up: assert property (p_turn_up) else $error("no turn to up at wrap");

	property p_start;
		start_req && !stop_req && state_reg == TPW_STOPPED && comp_mode |=> o_running;
	endproperty
	a_start: assert property (p_start) else $error("count did not start");

	property p_stop;
		stop_req |=> !o_running ##1 (o_running || pin_reg == $past(pin_reg));
	endproperty
	a_stop: assert property (p_stop) else $error("count did not stop");

	property p_period_fixed;
		o_running && comp_mode |=> period_reg == $past(period_reg);
	endproperty
	a_period_fixed: assert property (p_period_fixed) else $error("period changed");

	property p_buf_xfer;
		xfer && i_ch0_d_buffer_enable && !wr_cmp |=> cmp_reg[`TPW_B0] == $past(cmp_reg[`TPW_D0]);
	endproperty
	a_buf_xfer: assert property (p_buf_xfer) else $error("buffer not transferred");

	property p_udf_irq;
		comp_udf |=> o_underflow_irq ##1 !o_underflow_irq || $past(comp_udf);
	endproperty
	a_udf_irq: assert property (p_udf_irq) else $error("underflow irq missing");

	property p_dead;
		comp_mode && state_reg != TPW_STOPPED && cnt0_reg >= cnt1_reg |-> !(nrm_act[0] && ctr_act[0]);
	endproperty
	a_dead: assert property (p_dead) else $error("normal and counter overlap");

	c_comp_cycle: cover property (comp_top ##[1:1000] comp_udf);
	c_rs_wrap: cover property (rs_wrap ##[1:1000] rs_wrap);
	c_stop: cover property (o_running ##1 stop_req);
endmodule : tpw_timer

// ==== testbench/tpw_gate_model.sv ====
// gate-driver stand-in for the three inverter legs and the period pin.
// assumes it samples the pins on the same clock that launches them.
module tpw_gate_model (
	input wire logic i_clk, // system clock
	input wire logic i_sys_rst, // async reset, active high
	input wire logic [5:0] i_gate, // first_pwm_output n,c second_pwm_output n,c third_pwm_output n,c
	input wire logic i_period_pin, // ch0 c toggle pin
	output logic [31:0] o_width [0:5], // last finished high width, cycles
	output logic [31:0] o_half, // last interval between toggles, cycles
	output logic [31:0] o_overlap // cycles with both switches of a leg on
);
	logic [31:0] run [0:5];
	logic [31:0] since;
	logic last_pin;
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int k = 0; k < 6; k++) begin
				run[k] <= 0;
				o_width[k] <= 0;
			end
			since <= 0;
			last_pin <= 1'b0;
			o_half <= 0;
			o_overlap <= 0;
		end else begin
			// a pulse only counts once it has ended, so partial pulses never show
			for (int k = 0; k < 6; k++) begin
				if (i_gate[k]) begin
					run[k] <= run[k] + 1;
				end else if (run[k] != 0) begin
					o_width[k] <= run[k];
					run[k] <= 0;
				end
			end
			last_pin <= i_period_pin;
			if (i_period_pin != last_pin) begin
				o_half <= since + 1;
				since <= 0;
			end else begin
				since <= since + 1;
			end
			// a leg with both switches on would short the supply
			if ((i_gate[0] & i_gate[1]) | (i_gate[2] & i_gate[3]) | (i_gate[4] & i_gate[5])) begin
				o_overlap <= o_overlap + 1;
			end
		end
	end
endmodule : tpw_gate_model

// ==== testbench/testbench.sv ====
// self-checking bench for the three-phase pwm timer with a gate-driver model.
// assumes a free-running square wave on the external pin and oscillator inputs.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_sys_rst, i_wr_en, i_start_wr, i_ch0_start_bit, i_ch1_start_bit;
	logic i_ch0_stop_select, i_reset_sync_mode;
	logic [3:0] i_wr_index, i_rd_index, buf_en;
	logic [15:0] i_wr_data, o_rd_data;
	logic [1:0] i_combination_mode_select;
	logic [2:0] i_clock_source_select;
	logic [1:0] i_clock_edge_select;
	logic ext_pin = 1'b0;
	logic down_q;
	logic [5:0] i_output_control;
	logic o_ch0_c_output_pin, o_first_pwm_output_normal_pin, o_first_pwm_output_counter_pin, o_second_pwm_output_normal_pin;
	logic o_second_pwm_output_counter_pin, o_third_pwm_output_normal_pin, o_third_pwm_output_counter_pin;
	logic o_running, o_count_down, o_match_irq, o_underflow_irq;
	logic [31:0] wid [0:5];
	logic [31:0] half, overlap, v;
	int fails, tests_run, ufl_cnt, top_cnt, m, p, per;
	int nv [3];
	int shadow [10];
	int nidx [3] = '{3, 6, 7};
	int bidx [3] = '{5, 8, 9};

	tpw_timer dut_u (.i_clk, .i_sys_rst, .i_wr_en, .i_wr_index, .i_wr_data, .i_rd_index,
		.o_rd_data, .i_start_wr, .i_ch0_start_bit, .i_ch1_start_bit, .i_ch0_stop_select,
		.i_reset_sync_mode, .i_combination_mode_select,
		.i_ch0_c_buffer_enable(buf_en[0]), .i_ch0_d_buffer_enable(buf_en[1]),
		.i_ch1_c_buffer_enable(buf_en[2]), .i_ch1_d_buffer_enable(buf_en[3]),
		.i_clock_source_select, .i_clock_edge_select, .i_external_count_clock_pin(ext_pin),
		.i_onchip_oscillator_clock(ext_pin), .i_normal_level_select(1'b1),
		.i_counter_level_select(1'b1), .i_output_control, .o_ch0_c_output_pin,
		.o_first_pwm_output_normal_pin, .o_first_pwm_output_counter_pin, .o_second_pwm_output_normal_pin, .o_second_pwm_output_counter_pin,
		.o_third_pwm_output_normal_pin, .o_third_pwm_output_counter_pin, .o_running, .o_count_down, .o_match_irq,
		.o_underflow_irq);

	tpw_gate_model gate_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_gate({o_third_pwm_output_counter_pin, o_third_pwm_output_normal_pin, o_second_pwm_output_counter_pin,
			o_second_pwm_output_normal_pin, o_first_pwm_output_counter_pin, o_first_pwm_output_normal_pin}),
		.i_period_pin(o_ch0_c_output_pin), .o_width(wid), .o_half(half), .o_overlap(overlap));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	// a top turn raises count_down and must raise the match request on the same edge
	always @(posedge i_clk) begin
		if (o_underflow_irq === 1'b1) ufl_cnt++;
		if (o_count_down === 1'b1 && down_q === 1'b0 && o_match_irq === 1'b1) top_cnt++;
		down_q = o_count_down;
	end

	// square wave on the outside count pins: a rising edge every 8 cycles, any edge every 4
	always begin
		repeat (4) @(negedge i_clk);
		ext_pin = ~ext_pin;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input int idx, input int val);
		@(negedge i_clk);
		i_wr_en = 1'b1;
		i_wr_index = idx[3:0];
		i_wr_data = val[15:0];
		@(negedge i_clk);
		i_wr_en = 1'b0;
	endtask : wr

	task automatic rd(input int idx, output logic [31:0] val);
		@(negedge i_clk);
		i_rd_index = idx[3:0];
		@(negedge i_clk);
		val = {16'h0000, o_rd_data};
	endtask : rd

	task automatic start(input logic b0, input logic b1);
		@(negedge i_clk);
		i_start_wr = 1'b1;
		i_ch0_start_bit = b0;
		i_ch1_start_bit = b1;
		@(negedge i_clk);
		i_start_wr = 1'b0;
	endtask : start

	// expected pin timing from m, p and the three compare values
	task automatic pin_check(input bit comp, input int div);
		int ne;
		int ce;
		chk(half, comp ? (m + 2 - p) * div : m + 1);
		for (int k = 0; k < 3; k++) begin
			// reset-sync outputs stay active through the tick that matches n
			ne = comp ? 2 * (m - nv[k] - p + 1) * div : nv[k] + 1;
			ce = comp ? 2 * (nv[k] + 1 - p) * div : m - nv[k];
			chk(wid[2 * k], ne);
			chk(wid[2 * k + 1], ce);
		end
	endtask : pin_check

	task automatic rsync_run();
		i_reset_sync_mode = 1'b1;
		i_combination_mode_select = 2'h0;
		i_clock_source_select = 3'h0;
		i_output_control = 6'($urandom % 64);
		buf_en = 4'h0;
		m = 20 + $urandom % 8;
		for (int k = 0; k < 3; k++) nv[k] = 1 + $urandom % (m - 1);
		wr(0, 0);
		wr(2, m);
		for (int k = 0; k < 3; k++) wr(nidx[k], nv[k]);
		start(1'b1, 1'b1);
		chk(o_running, 1);
		repeat (4 * (m + 1)) @(negedge i_clk);
		pin_check(1'b0, 1);
		m = m + 6;
		for (int k = 0; k < 3; k++) nv[k] = 1 + $urandom % (m - 1);
		wr(4, m);
		for (int k = 0; k < 3; k++) wr(bidx[k], nv[k]);
		// enable only once every buffer holds its new value, else a wrap copies stale words
		buf_en = 4'hf;
		repeat (4 * (m + 1)) @(negedge i_clk);
		pin_check(1'b0, 1);
		$display("test reset_sync done");
	endtask : rsync_run

	task automatic comp_run(input int s, input logic [1:0] mode);
		int div;
		div = (s == 4) ? 32 : (s == 5) ? 4 : (s == 6) ? 8 : (1 << s);
		i_ch0_stop_select = 1'b1;
		start(1'b0, 1'b0);
		i_reset_sync_mode = 1'b0;
		i_combination_mode_select = mode;
		i_clock_source_select = s[2:0];
		i_clock_edge_select = (s == 5) ? 2'h2 : 2'h0;
		i_output_control = 6'h00;
		buf_en = 4'he;
		m = 20 + $urandom % 6;
		p = 1 + $urandom % 3;
		for (int k = 0; k < 3; k++) nv[k] = p + 1 + $urandom % (m - 2 * p - 1);
		wr(0, p);
		wr(1, 0);
		wr(2, m);
		for (int k = 0; k < 3; k++) wr(nidx[k], nv[k]);
		for (int k = 0; k < 3; k++) wr(bidx[k], nv[k]);
		start(1'b1, 1'b1);
		chk(o_running, 1);
		per = 2 * (m + 2 - p) * div;
		repeat (3 * per) @(negedge i_clk);
		pin_check(1'b1, div);
		ufl_cnt = 0;
		top_cnt = 0;
		repeat (2 * per) @(negedge i_clk);
		chk(ufl_cnt, 2);
		chk(top_cnt, 2);
		for (int k = 0; k < 3; k++) nv[k] = p + 1 + $urandom % (m - 2 * p - 1);
		for (int k = 0; k < 3; k++) wr(bidx[k], nv[k]);
		wr(2, m + 4);
		// a transfer may land late in the first period, so allow a third
		repeat (3 * per) @(negedge i_clk);
		pin_check(1'b1, div);
		i_ch0_stop_select = 1'b0;
		start(1'b0, 1'b0);
		chk(o_running, 1);
		i_ch0_stop_select = 1'b1;
		start(1'b0, 1'b0);
		chk(o_running, 0);
		$display("test complementary source %0d mode %0d done", s, mode);
	endtask : comp_run

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	// all tests together take well under half of this span
	initial begin
		repeat (60000) @(posedge i_clk);
		fails++;
		$display("watchdog expired at %0t", $time);
		test_done();
	end

	initial begin
		{i_wr_en, i_start_wr, i_ch0_start_bit, i_ch1_start_bit, i_ch0_stop_select} = 5'h00;
		{i_reset_sync_mode, i_combination_mode_select, buf_en} = 7'h00;
		{i_wr_index, i_rd_index, i_wr_data} = 24'h000000;
		i_clock_source_select = 3'h0;
		i_clock_edge_select = 2'h0;
		i_output_control = 6'h00;
		i_sys_rst = 1'b1;
		void'($urandom(59810));
		repeat (10) @(negedge i_clk);
		i_sys_rst = 1'b0;
		for (int k = 0; k < 10; k++) begin
			shadow[k] = $urandom % 65536;
			wr(k, shadow[k]);
		end
		for (int k = 0; k < 10; k++) begin
			rd(k, v);
			chk(v, shadow[k]);
		end
		rd(10, v);
		chk(v, 0);
		$display("test registers done");
		rsync_run();
		for (int s = 0; s < 7; s++) comp_run(s, (s % 2) ? 2'h3 : 2'h2);
		chk(overlap, 0);
		test_done();
	end
endmodule : testbench
